// ### design/pwr_down_pkg.sv
// Package for the power-down controller: register map, field layout,
// reset values, settling counts and the mode enumeration.
// Assumes one 40 MHz system clock and an 8-bit register port.
package pwr_down_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [15:0] SYSCTL_ADDR   = 16'hffc4;
  localparam logic [15:0] PD_STAT_ADDR  = 16'hffc6;
  localparam logic [7:0]  SYSCTL_RESET  = 8'h09;
  localparam logic [7:0]  SYSCTL_WMASK  = 8'hf7;
  localparam int          STANDBY_SELECT_POS      = 7;
  localparam int          STS_LSB       = 4;
  localparam int          RSRC_POS      = 3;

  // ---------------------------------------------------------------
  // Settling counts in system clock states
  // ---------------------------------------------------------------
  localparam int CNT_W          = 18;
  localparam int SETTLE_CNT_0   = 8192;
  localparam int SETTLE_CNT_1   = 16384;
  localparam int SETTLE_CNT_2   = 32768;
  localparam int SETTLE_CNT_3   = 65536;
  localparam int SETTLE_CNT_4   = 131072;
  localparam int SETTLE_CNT_FST = 1024;
  localparam int SYS_CLK_MHZ    = 40;
  localparam int MIN_SETTLE_MS  = 8;
  localparam int MIN_SETTLE_CYC = MIN_SETTLE_MS * 1000 * SYS_CLK_MHZ;

  typedef enum logic [2:0] {
    PD_RUN    = 3'b000,
    PD_SLEEP  = 3'b001,
    PD_SWSTBY = 3'b010,
    PD_SETTLE = 3'b011,
    PD_HWSTBY = 3'b100
  } pd_mode_t;

  typedef struct packed {
    logic       standby_select;
    logic [2:0] settle_time_sel;
    logic       reset_source_flag;
    logic       nmi_edge_select;
    logic       host_if_enable;
    logic       onchip_ram_enable;
  } system_control_reg_t;

  typedef struct packed {
    logic osc_run;
    logic sys_clk_run;
    logic cpu_run;
    logic cpu_reset;
    logic periph_run;
    logic periph_init;
    logic port_hiz;
    logic int_start;
  } pd_ctl_t;

endpackage

// ### design/settle_counter.sv
// Oscillator settling counter: loads a state count and reports when
// it has run out.
// Assumes start is a one-cycle pulse from the same clock domain.
`timescale 1ns/10ps
module settle_counter #(
  parameter int CNT_W = 18
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_start,
  input  wire logic             i_abort,
  input  wire logic [CNT_W-1:0] i_target,
  output logic                  o_done
);
  import pwr_down_pkg::*;

  typedef struct packed {
    logic             running;
    logic [CNT_W-1:0] remain;
  } cnt_state_t;

  cnt_state_t st;
  cnt_state_t next_st;

  if (CNT_W < 2) begin : g_bad_width
    $error("settle_counter: CNT_W too small");
  end

  // Counts from the restart of the oscillator; done marks the last state
  always_comb begin
    next_st = st;
    o_done  = st.running && (st.remain == '0);
    if (i_abort) begin
      next_st.running = 1'b0;
    end else if (i_start) begin
      next_st.running = 1'b1;
      next_st.remain  = i_target - 1'b1;
    end else if (st.running) begin
      if (st.remain == '0) begin
        next_st.running = 1'b0;
      end else begin
        next_st.remain = st.remain - 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  count_down_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st.running && st.remain != '0 && !i_abort && !i_start
      |=> st.remain == $past(st.remain) - 1'b1)
    else $error("settle count did not step down");

endmodule

// ### design/power_down_ctl.sv
// Power-down mode controller: system control register, sleep,
// software standby with oscillator settling, and hardware standby.
// Assumes the CPU gives a one-cycle sleep pulse and an interrupt
// request level on this clock; standby, wake and key pins are async.
//
// Operation
// - Sleep instruction with standby select 0 halts CPU, clock and peripherals run
// - Standby select stays 1 after interrupt wake; only software clears it (the code also clears it on the standby pin and on either reset)
// - Wake interrupt runs oscillator for chosen settle time, CPU stays stopped
// - Codes 000-011 give 8192-65536 states, 10x gives 131072, 11x unused
// - Flash variant: 100 gives 131072 states, 101 gives 1024 states
// - System control register resets to 0x09, or to 0x01 on a watchdog reset, with the documented bit layout
// - Sleep ends on any enabled interrupt, reset or standby pin
// - Software standby ends only on reset, standby pin or external wake
// - Interrupt wake restarts oscillator, waits, restores clock, starts handling
`timescale 1ns/10ps
module power_down_ctl #(
  parameter bit FLASH_VARIANT  = 1'b0,
  parameter int CNT_SEL_0      = pwr_down_pkg::SETTLE_CNT_0,
  parameter int CNT_SEL_1      = pwr_down_pkg::SETTLE_CNT_1,
  parameter int CNT_SEL_2      = pwr_down_pkg::SETTLE_CNT_2,
  parameter int CNT_SEL_3      = pwr_down_pkg::SETTLE_CNT_3,
  parameter int CNT_SEL_4      = pwr_down_pkg::SETTLE_CNT_4,
  parameter int CNT_SEL_FAST   = pwr_down_pkg::SETTLE_CNT_FST,
  parameter int MIN_SETTLE_CNT = pwr_down_pkg::MIN_SETTLE_CYC
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_wdt_rst,
  input  wire logic [15:0]           i_addr,
  input  wire logic [7:0]            i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic [7:0]                 o_rdata,
  input  wire logic                  i_sleep_exec,
  input  wire logic                  i_int_req,
  input  wire logic                  i_ext_wake,
  input  wire logic [15:0]           i_key_wake_inputs_n,
  input  wire logic                  i_hw_standby_pin_n,
  output pwr_down_pkg::pd_ctl_t      o_pd_ctl,
  output pwr_down_pkg::pd_mode_t     o_mode,
  output logic                       o_nmi_edge_select,
  output logic                       o_host_if_enable,
  output logic                       o_onchip_ram_enable
);
  import pwr_down_pkg::*;

  if (CNT_SEL_0 < 1 || CNT_SEL_1 < 1 || CNT_SEL_2 < 1 || CNT_SEL_3 < 1 ||
      CNT_SEL_4 < 1 || CNT_SEL_FAST < 1 || CNT_SEL_4 >= (1 << CNT_W))
  begin : g_bad_count
    $error("power_down_ctl: settle counts out of range");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]          hw_standby_pin_n_sync;
    logic [1:0]          wake_sync;
    logic [1:0]          key_sync;
    pd_mode_t            mode;
    system_control_reg_t sysctl;
    logic [7:0]          rdata;
    logic                int_start;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;
  logic       settle_start;
  logic       settle_done;
  logic [CNT_W-1:0] settle_target;

  // Unused codes fall back to the longest count so the clock never
  // restarts early on a misprogrammed part.
  function automatic logic [CNT_W-1:0] settle_count(input logic [2:0] code);
    case (code)
      3'b000:  settle_count = CNT_W'(CNT_SEL_0);
      3'b001:  settle_count = CNT_W'(CNT_SEL_1);
      3'b010:  settle_count = CNT_W'(CNT_SEL_2);
      3'b011:  settle_count = CNT_W'(CNT_SEL_3);
      3'b101:  settle_count = FLASH_VARIANT ? CNT_W'(CNT_SEL_FAST)
                                            : CNT_W'(CNT_SEL_4);
      default: settle_count = CNT_W'(CNT_SEL_4);
    endcase
  endfunction

  assign settle_target = settle_count(st.sysctl.settle_time_sel);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic hw_standby_pin_n_low;
    logic ext_wake;
    logic too_short;
    hw_standby_pin_n_low  = !st.hw_standby_pin_n_sync[1];
    ext_wake  = st.wake_sync[1] || st.key_sync[1];
    // Compared at full integer width: the minimum may not fit the counter
    too_short = int'(settle_target) < MIN_SETTLE_CNT;
    next_st   = st;
    settle_start = 1'b0;
    next_st.hw_standby_pin_n_sync = {st.hw_standby_pin_n_sync[0], i_hw_standby_pin_n};
    next_st.wake_sync = {st.wake_sync[0], i_ext_wake};
    next_st.key_sync  = {st.key_sync[0], ~&i_key_wake_inputs_n};
    next_st.int_start = 1'b0;
    next_st.rdata     = 8'h00;

    if (i_rd && i_addr == SYSCTL_ADDR) begin
      next_st.rdata = st.sysctl;
    end else if (i_rd && i_addr == PD_STAT_ADDR) begin
      next_st.rdata = {4'h0, too_short, st.mode};
    end
    if (i_wr && i_addr == SYSCTL_ADDR) begin
      // Reset-source flag is read-only
      next_st.sysctl = (i_wdata & SYSCTL_WMASK) |
                       (st.sysctl & ~SYSCTL_WMASK);
    end

    if (hw_standby_pin_n_low) begin
      next_st.mode   = PD_HWSTBY;
      next_st.sysctl = SYSCTL_RESET;
    end else begin
      case (st.mode)
        PD_RUN: begin
          if (i_sleep_exec) begin
            next_st.mode = st.sysctl.standby_select ? PD_SWSTBY
                                                    : PD_SLEEP;
          end
        end
        PD_SLEEP: begin
          if (i_int_req || ext_wake) begin
            next_st.mode      = PD_RUN;
            next_st.int_start = 1'b1;
          end
        end
        PD_SWSTBY: begin
          // Internal interrupts cannot run without the clock
          if (ext_wake) begin
            next_st.mode = PD_SETTLE;
            settle_start = 1'b1;
          end
        end
        PD_SETTLE: begin
          if (settle_done) begin
            next_st.mode      = PD_RUN;
            next_st.int_start = 1'b1;
          end
        end
        // Left only by the system reset or the watchdog reset
        PD_HWSTBY: next_st.mode = PD_HWSTBY;
        default:   next_st.mode = PD_RUN;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st            <= '0;
      st.hw_standby_pin_n_sync  <= 2'b11;
      st.mode       <= PD_RUN;
      st.sysctl     <= SYSCTL_RESET;
    end else if (i_wdt_rst) begin
      st            <= '0;
      st.hw_standby_pin_n_sync  <= 2'b11;
      st.mode       <= PD_RUN;
      st.sysctl     <= SYSCTL_RESET & ~(8'h01 << RSRC_POS);
    end else begin
      st <= next_st;
    end
  end

  settle_counter #(
    .CNT_W (CNT_W)
  ) u_settle (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_start   (settle_start),
    .i_abort   (st.mode != PD_SETTLE && st.mode != PD_SWSTBY),
    .i_target  (settle_target),
    .o_done    (settle_done)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Oscillator restarts in settling while the chip clock stays gated
  assign o_pd_ctl.osc_run     = st.mode inside {PD_RUN, PD_SLEEP, PD_SETTLE};
  assign o_pd_ctl.sys_clk_run = st.mode inside {PD_RUN, PD_SLEEP};
  assign o_pd_ctl.cpu_run     = st.mode == PD_RUN;
  assign o_pd_ctl.cpu_reset   = st.mode == PD_HWSTBY;
  assign o_pd_ctl.periph_run  = st.mode inside {PD_RUN, PD_SLEEP};
  assign o_pd_ctl.periph_init = st.mode inside {PD_SWSTBY, PD_SETTLE,
                                                PD_HWSTBY};
  assign o_pd_ctl.port_hiz    = st.mode == PD_HWSTBY;
  assign o_pd_ctl.int_start   = st.int_start;
  assign o_mode               = st.mode;
  assign o_rdata              = st.rdata;
  assign o_nmi_edge_select    = st.sysctl.nmi_edge_select;
  assign o_host_if_enable     = st.sysctl.host_if_enable;
  assign o_onchip_ram_enable  = st.sysctl.onchip_ram_enable;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] settle_len;
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || st.mode != PD_SETTLE) begin
      settle_len <= '0;
    end else begin
      settle_len <= settle_len + 1'b1;
    end
  end

  sleep_entry_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st.mode == PD_RUN && i_sleep_exec && !st.sysctl.standby_select &&
    st.hw_standby_pin_n_sync[1] && !i_wdt_rst
      |=> o_mode == PD_SLEEP && o_pd_ctl.sys_clk_run && !o_pd_ctl.cpu_run)
    else $error("sleep not entered");
  swstby_entry_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st.mode == PD_RUN && i_sleep_exec && st.sysctl.standby_select &&
    st.hw_standby_pin_n_sync[1] && !i_wdt_rst
      |=> !o_pd_ctl.osc_run && o_pd_ctl.periph_init && !o_pd_ctl.cpu_run)
    else $error("software standby not entered");
  standby_select_keep_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st.mode == PD_SETTLE && settle_done && st.hw_standby_pin_n_sync[1] && !i_wdt_rst
      |=> st.sysctl.standby_select)
    else $error("standby select lost on wake");
  settle_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st.mode == PD_SETTLE |-> o_pd_ctl.osc_run && !o_pd_ctl.cpu_run &&
      !o_pd_ctl.sys_clk_run)
    else $error("clock released during settling");
  settle_len_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st.mode == PD_SETTLE && settle_done && !st.sysctl.settle_time_sel[2]
      |-> settle_len + 1'b1 ==
          (st.sysctl.settle_time_sel[1:0] == 2'b00 ? CNT_W'(CNT_SEL_0) :
           st.sysctl.settle_time_sel[1:0] == 2'b01 ? CNT_W'(CNT_SEL_1) :
           st.sysctl.settle_time_sel[1:0] == 2'b10 ? CNT_W'(CNT_SEL_2) :
                                                     CNT_W'(CNT_SEL_3)))
    else $error("settle length wrong");
  settle_hi_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st.mode == PD_SETTLE && settle_done && st.sysctl.settle_time_sel == 3'b101
      |-> settle_len + 1'b1 == (FLASH_VARIANT ? CNT_W'(CNT_SEL_FAST)
                                             : CNT_W'(CNT_SEL_4)))
    else $error("fast settle length wrong");
  hw_standby_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    !st.hw_standby_pin_n_sync[1] && !i_wdt_rst |=> o_pd_ctl.port_hiz &&
      st.sysctl == SYSCTL_RESET)
    else $error("hardware standby not entered");
  sysctl_reset_a: assert property (@(posedge i_sys_clk)
    i_sys_rst |=> st.sysctl == SYSCTL_RESET && o_rdata == 8'h00)
    else $error("system control reset value wrong");
  sleep_exit_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st.mode == PD_SLEEP && i_int_req && st.hw_standby_pin_n_sync[1] && !i_wdt_rst
      |=> o_mode == PD_RUN && o_pd_ctl.int_start)
    else $error("sleep not left on interrupt");
  swstby_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st.mode == PD_SWSTBY && !st.wake_sync[1] && !st.key_sync[1] &&
    st.hw_standby_pin_n_sync[1] && !i_wdt_rst |=> o_mode == PD_SWSTBY)
    else $error("software standby left without wake");
  wake_int_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
    st.mode == PD_SETTLE && settle_done && st.hw_standby_pin_n_sync[1] && !i_wdt_rst
      |=> o_pd_ctl.int_start && o_pd_ctl.sys_clk_run ##1 !o_pd_ctl.int_start)
    else $error("wake handling not started");

  sleep_c: cover property (@(posedge i_sys_clk) o_mode == PD_SLEEP);
  settle_c: cover property (@(posedge i_sys_clk)
    st.mode == PD_SETTLE && settle_done);
  hwstby_c: cover property (@(posedge i_sys_clk) o_mode == PD_HWSTBY);
  key_wake_c: cover property (@(posedge i_sys_clk)
    st.mode == PD_SWSTBY && st.key_sync[1]);

endmodule

// ### sim/cpu_pin_model.sv
// Model of the CPU core and the wake, key and standby pins around the
// power-down controller. Assumes the bench calls its tasks in order.
`timescale 1ns/10ps
module cpu_pin_model (
  input  wire logic        i_sys_clk,
  output logic             o_sleep_exec,
  output logic             o_int_req,
  output logic             o_ext_wake,
  output logic [15:0]      o_key_n,
  output logic             o_hw_standby_pin_n_n
);
  // Key and standby pins have pull-ups, so their idle level is high
  initial begin
    o_sleep_exec = 1'b0;
    o_int_req    = 1'b0;
    o_ext_wake   = 1'b0;
    o_key_n      = 16'hffff;
    o_hw_standby_pin_n_n     = 1'b1;
  end

  // ---------------------------------------------------------------
  // Core side
  // ---------------------------------------------------------------
  task automatic sleep_pulse();
    @(posedge i_sys_clk);
    o_sleep_exec <= 1'b1;
    @(posedge i_sys_clk);
    o_sleep_exec <= 1'b0;
  endtask

  task automatic int_level(input logic v);
    @(posedge i_sys_clk);
    o_int_req <= v;
  endtask

  // ---------------------------------------------------------------
  // Pin side
  // ---------------------------------------------------------------
  // Held long enough to pass the two-flop synchroniser, then released
  task automatic wake(input logic use_key, input logic [3:0] key);
    @(posedge i_sys_clk);
    if (use_key) begin
      o_key_n[key] <= 1'b0;
    end else begin
      o_ext_wake <= 1'b1;
    end
    repeat (4) @(posedge i_sys_clk);
    o_key_n    <= 16'hffff;
    o_ext_wake <= 1'b0;
  endtask

  task automatic set_hw_standby_pin_n(input logic v);
    @(posedge i_sys_clk);
    o_hw_standby_pin_n_n <= v;
  endtask
endmodule

// ### sim/power_down_ctl_tb.sv
// Self-checking bench for the power-down controller with short counts.
// Assumes the flash variant and the shortened settling parameters.
`timescale 1ns/10ps
module power_down_ctl_tb;
  import pwr_down_pkg::*;
  logic        i_sys_clk, i_sys_rst, i_wdt_rst, i_wr, i_rd;
  logic [15:0] i_addr, key_n, rnd_addr;
  logic [7:0]  i_wdata, o_rdata, r;
  logic        sleep_x, int_req, ext_wake, hw_standby_pin_n_n, rd_q, was_settle;
  logic        o_nmi, o_host, o_ram;
  pd_ctl_t     o_pd_ctl;
  pd_mode_t    o_mode;
  logic [7:0]  exp_rd[$];
  int          exp_cnt[$];
  int          n_errors, check_count, settle_n, seed, c, k;
  // Settling states per code with the shortened parameters below
  localparam int CNT_TAB [8] = '{8, 12, 16, 20, 24, 4, 24, 24};
  localparam int MIN_CNT = 10;

  power_down_ctl #(.FLASH_VARIANT(1'b1), .CNT_SEL_0(CNT_TAB[0]),
    .CNT_SEL_1(CNT_TAB[1]), .CNT_SEL_2(CNT_TAB[2]), .CNT_SEL_3(CNT_TAB[3]),
    .CNT_SEL_4(CNT_TAB[4]), .CNT_SEL_FAST(CNT_TAB[5]),
    .MIN_SETTLE_CNT(MIN_CNT)) u_power_down_ctl (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_wdt_rst(i_wdt_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_sleep_exec(sleep_x), .i_int_req(int_req),
    .i_ext_wake(ext_wake), .i_key_wake_inputs_n(key_n),
    .i_hw_standby_pin_n(hw_standby_pin_n_n), .o_pd_ctl(o_pd_ctl), .o_mode(o_mode),
    .o_nmi_edge_select(o_nmi), .o_host_if_enable(o_host),
    .o_onchip_ram_enable(o_ram));

  cpu_pin_model u_cpu_pin_model (.i_sys_clk(i_sys_clk),
    .o_sleep_exec(sleep_x), .o_int_req(int_req), .o_ext_wake(ext_wake),
    .o_key_n(key_n), .o_hw_standby_pin_n_n(hw_standby_pin_n_n));

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic cmp8(input string what, input logic [7:0] e,
                      input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_cnt(input string what, input int e, input int g);
    check_count++;
    if (g != e) begin
      n_errors++;
      $display("[ERR] %s expected %0d seen %0d", what, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    exp_rd.push_back(e);
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
  endtask

  task automatic chk_state(input pd_mode_t m, input logic [7:0] ctl);
    #1;
    cmp8("mode", {5'h0, m}, {5'h0, o_mode});
    cmp8("pd_ctl", ctl, o_pd_ctl);
  endtask

  task automatic wait_mode(input pd_mode_t m);
    for (k = 0; k < 60 && o_mode !== m; k++) @(posedge i_sys_clk);
    cmp8("mode wait", {5'h0, m}, {5'h0, o_mode});
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Result monitor
  // ---------------------------------------------------------------
  always @(posedge i_sys_clk) rd_q <= i_rd;

  // Sampled mid-cycle so design flops have settled
  always @(negedge i_sys_clk) begin
    if (rd_q) cmp8("rdata", exp_rd.pop_front(), o_rdata);
    if (o_mode === PD_SETTLE) begin
      settle_n++;
    end else if (was_settle) begin
      cmp_cnt("settle states", exp_cnt.pop_front(), settle_n);
      cmp8("wake ctl", 8'he9, o_pd_ctl);
      settle_n = 0;
    end
    was_settle = (o_mode === PD_SETTLE);
  end

  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  // Whole run is near 400 cycles; cut off after about 8,000
  initial begin
    #200000;
    n_errors++;
    test_done();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 55425;
    n_errors = 0;
    check_count = 0;
    settle_n = 0;
    was_settle = 1'b0;
    {i_wr, i_rd, i_wdt_rst, i_addr, i_wdata} = '0;
    i_sys_rst = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    rd(SYSCTL_ADDR, SYSCTL_RESET);
    wr(SYSCTL_ADDR, 8'h00);
    rd(SYSCTL_ADDR, 8'h08);
    rd(16'hffc5, 8'h00);
    r = 8'($random(seed)) & 8'h07;
    wr(SYSCTL_ADDR, r);
    #1 cmp8("low bits", {5'h0, r[2:0]}, {5'h0, o_nmi, o_host, o_ram});
    rnd_addr = {1'b0, 15'($random(seed))};
    wr(rnd_addr, 8'($random(seed)));
    rd(rnd_addr, 8'h00);
    rd(SYSCTL_ADDR, {5'h01, r[2:0]});
    u_cpu_pin_model.sleep_pulse();
    chk_state(PD_SLEEP, 8'hc8);
    u_cpu_pin_model.int_level(1'b1);
    @(posedge i_sys_clk);
    chk_state(PD_RUN, 8'he9);
    u_cpu_pin_model.int_level(1'b0);
    for (c = 0; c < 6; c++) begin
      // Standby select and code c go in just before sleep, 00 written after wake, leaving 08 as the flag is read-only
      wr(SYSCTL_ADDR, {1'b1, c[2:0], 4'h0});
      rd(PD_STAT_ADDR, {4'h0, CNT_TAB[c] < MIN_CNT, 3'b000});
      u_cpu_pin_model.sleep_pulse();
      chk_state(PD_SWSTBY, 8'h04);
      u_cpu_pin_model.int_level(1'b1);
      repeat (4) @(posedge i_sys_clk);
      chk_state(PD_SWSTBY, 8'h04);
      u_cpu_pin_model.int_level(1'b0);
      exp_cnt.push_back(CNT_TAB[c]);
      u_cpu_pin_model.wake(c[0], 4'($random(seed)));
      #1 cmp8("osc_run", 8'h01, {7'h0, o_pd_ctl.osc_run});
      wait_mode(PD_RUN);
      rd(SYSCTL_ADDR, {1'b1, c[2:0], 4'h8});
      wr(SYSCTL_ADDR, 8'h00);
    end
    cmp_cnt("settle runs left", 0, exp_cnt.size());
    // Every key pin wakes the chip from sleep
    for (c = 0; c < 16; c++) begin
      u_cpu_pin_model.sleep_pulse();
      u_cpu_pin_model.wake(1'b1, c[3:0]);
      wait_mode(PD_RUN);
    end
    u_cpu_pin_model.sleep_pulse();
    u_cpu_pin_model.set_hw_standby_pin_n(1'b0);
    wait_mode(PD_HWSTBY);
    chk_state(PD_HWSTBY, 8'h16);
    wr(SYSCTL_ADDR, 8'h80);
    rd(SYSCTL_ADDR, SYSCTL_RESET);
    u_cpu_pin_model.set_hw_standby_pin_n(1'b1);
    @(posedge i_sys_clk);
    i_sys_rst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    chk_state(PD_RUN, 8'he8);
    @(posedge i_sys_clk);
    i_wdt_rst <= 1'b1;
    @(posedge i_sys_clk);
    i_wdt_rst <= 1'b0;
    rd(SYSCTL_ADDR, 8'h01);
    wr(SYSCTL_ADDR, 8'h08);
    rd(SYSCTL_ADDR, 8'h00);
    repeat (3) @(posedge i_sys_clk);
    test_done();
  end
endmodule
